// File: bench/dac_quadrature_datapath_trim_tb_top.sv
// Self-checking bench for the quadrature trim datapath.
// Assumes APB master and sample source on one 200 MHz clock.
`timescale 1ns/1ps
`include "dqdt_defines.svh"
module dac_quadrature_datapath_trim_tb_top
  import dqdt_pkg::*;
;
  logic         mclk;
  logic         reset_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  dqdt_sample_s samp_in;
  dqdt_sample_s samp_out;
  logic [31:0]  r;
  logic         e;
  logic [15:0]  oq_i[$];
  logic [15:0]  oq_q[$];
  int           errors;
  int           num_checks;

  dqdt_top u_dqdt_top (
    .mclk_i(mclk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .samp_i(samp_in), .samp_o(samp_out));
  dqdt_host_model u_dqdt_host_model (.mclk_i(mclk), .samp_o(samp_in));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (samp_out.valid === 1'b1) begin
      oq_i.push_back(samp_out.i);
      oq_q.push_back(samp_out.q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic chk_samp(input string n, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected apb timeout");
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_out(input int n);
    int k;
    k = 0;
    while (oq_i.size() < n && k < 50) begin
      @(posedge mclk);
      k++;
    end
    if (oq_i.size() < n) begin
      errors++;
      $display("unexpected sample timeout");
      finish_test();
    end
  endtask

  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    oq_i.delete();
    oq_q.delete();
  endtask

  function automatic logic [31:0] mix_exp(input int m, input int p, input logic [15:0] i,
                                          input logic [15:0] q);
    int k;
    case (m)
      1: k = (p % 2) * 2;
      2: k = p % 4;
      3: k = (p % 2) ? (p + 2) % 4 : p % 4;
      4: k = (p / 2) % 4;
      default: k = 0;
    endcase
    case (k)
      0: return {i, q};
      1: return {q, -i};
      2: return {-i, -q};
      default: return {-q, i};
    endcase
  endfunction

  function automatic logic [15:0] trim_exp(input logic [15:0] x, input logic [15:0] y,
                                           input logic [9:0] c);
    longint p;
    p = longint'($signed(c)) * longint'($signed(y)) * 1001;
    return x - 16'(p >>> 24);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] v;
    apb(1'b0, `DQDT_IDX_CFG, 8'h00);
    chk_reg("cfg reset", 32'h40, r);
    for (int a = 8'h38; a <= 8'h3f; a++) begin
      v = (a == 8'h39 || a == 8'h3b) ? 8'h02 : a[7:0] ^ 8'h96;
      apb(1'b0, a[7:0], 8'h00);
      chk_reg("trim reset", 32'h0, r);
      apb(1'b1, a[7:0], v);
      apb(1'b0, a[7:0], 8'h00);
      chk_reg("trim rw", {24'h0, v}, r);
    end
    apb(1'b0, 8'h10, 8'h00);
    chk_reg("unmapped err", 32'h1, {31'h0, e});
    chk_reg("unmapped data", 32'h0, r);
  endtask

  task automatic test_mix(input int m);
    logic [31:0] x;
    do_reset();
    apb(1'b1, `DQDT_IDX_CTRL, m[7:0]);
    for (int p = 0; p < 8; p++) u_dqdt_host_model.send(16'h1234 + p[15:0], 16'h0567 - p[15:0]);
    u_dqdt_host_model.pause(1);
    wait_out(8);
    for (int p = 0; p < 8; p++) begin
      x = mix_exp(m, p, 16'h1234 + p[15:0], 16'h0567 - p[15:0]);
      if (m != 4 || p % 2 == 0) begin
        chk_samp("mix i", x[31:16], oq_i[p]);
        chk_samp("mix q", x[15:0], oq_q[p]);
      end
    end
  endtask

  task automatic test_trim();
    logic [9:0] c[2] = '{10'h200, 10'h1ff};
    foreach (c[n]) begin
      do_reset();
      apb(1'b1, `DQDT_IDX_ITRIM_A, c[n][7:0]);
      apb(1'b1, `DQDT_IDX_ITRIM_B, {6'h0, c[n][9:8]});
      apb(1'b1, `DQDT_IDX_QTRIM_A, c[n][7:0]);
      apb(1'b1, `DQDT_IDX_QTRIM_B, {6'h0, c[n][9:8]});
      u_dqdt_host_model.send(16'h0000, 16'h4000);
      u_dqdt_host_model.send(16'h4000, 16'h0000);
      u_dqdt_host_model.pause(1);
      wait_out(2);
      chk_samp("trim i", trim_exp(16'h0, 16'h4000, c[n]), oq_i[0]);
      chk_samp("trim q", trim_exp(16'h0, 16'h4000, c[n]), oq_q[1]);
    end
  endtask

  task automatic test_offset();
    do_reset();
    apb(1'b1, `DQDT_IDX_DC0, 8'h00);
    apb(1'b1, `DQDT_IDX_DC0 + 8'h1, 8'h01);
    apb(1'b1, `DQDT_IDX_DC0 + 8'h2, 8'h00);
    apb(1'b1, `DQDT_IDX_DC3, 8'h80);
    u_dqdt_host_model.send(16'h1000, 16'h0010);
    u_dqdt_host_model.send(16'h7f80, 16'h8000);
    u_dqdt_host_model.pause(1);
    wait_out(2);
    chk_samp("dc i", 16'h1100, oq_i[0]);
    chk_samp("dc q", 16'h8010, oq_q[0]);
    chk_samp("sat i", 16'h7fff, oq_i[1]);
    chk_samp("sat q", 16'h8000, oq_q[1]);
    apb(1'b0, `DQDT_IDX_STAT, 8'h00);
    chk_reg("sat flag", 32'h1, {31'h0, r[12]});
  endtask

  task automatic test_rate();
    logic [7:0]  cfg[10] = '{8'h00, 8'h20, 8'h60, 8'h70, 8'h08,
                             8'h18, 8'h28, 8'h38, 8'h68, 8'h78};
    logic [11:0] lim[10] = '{12'd1230, 12'd1230, 12'd1230, 12'd615, 12'd2460,
                             12'd2000, 12'd2460, 12'd1230, 12'd1230, 12'd615};
    do_reset();
    foreach (cfg[n]) begin
      apb(1'b1, `DQDT_IDX_CTRL, cfg[n]);
      apb(1'b0, `DQDT_IDX_STAT, 8'h00);
      chk_reg("rate", {20'h0, lim[n]}, {19'h0, r[12:0]});
    end
  endtask

  task automatic test_sinc();
    do_reset();
    apb(1'b1, `DQDT_IDX_CFG, 8'h00);
    apb(1'b0, `DQDT_IDX_CFG, 8'h00);
    chk_reg("cfg bypass off", 32'h0, r);
    repeat (12) u_dqdt_host_model.send(16'h0100, 16'h0000);
    u_dqdt_host_model.pause(1);
    wait_out(12);
    chk_samp("sinc first", 16'h0001, oq_i[0]);
    chk_samp("sinc eighth", 16'h00b0, oq_i[7]);
    chk_samp("sinc ninth", 16'h00b1, oq_i[8]);
    chk_samp("sinc q", 16'h0000, oq_q[11]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_reset();
    test_regs();
    for (int m = 0; m < 6; m++) test_mix(m);
    test_trim();
    test_offset();
    test_rate();
    test_sinc();
    finish_test();
  end
endmodule

// File: bench/dqdt_host_model.sv
// Host sample source for the quadrature trim datapath.
// Assumes the bench calls its tasks; drives on the rising edge.
`timescale 1ns/1ps
module dqdt_host_model
  import dqdt_pkg::*;
(
  // Clock
  input  wire logic   mclk_i,
  // Samples to the datapath
  output dqdt_sample_s samp_o
);
  logic [15:0] last_i;
  logic [15:0] last_q;

  initial begin
    samp_o = '0;
    last_i = '0;
    last_q = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One complex twos complement sample per call
  task automatic send(input logic [15:0] i, input logic [15:0] q);
    @(posedge mclk_i);
    samp_o <= '{valid: 1'b1, i: i, q: q};
    last_i = i;
    last_q = q;
  endtask

  // Idle bus shows the inverse of the last value
  task automatic pause(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      samp_o <= '{valid: 1'b0, i: ~last_i, q: ~last_q};
    end
  endtask
endmodule

// File: design/dqdt_defines.svh
// Constants of the quadrature trim datapath.
// Assumes APB register access and samples on the sample clock.
`ifndef DQDT_DEFINES_SVH
`define DQDT_DEFINES_SVH
// Register indices, byte address is four times the index
`define DQDT_IDX_CFG     8'h1b
`define DQDT_IDX_ITRIM_A 8'h38
`define DQDT_IDX_ITRIM_B 8'h39
`define DQDT_IDX_QTRIM_A 8'h3a
`define DQDT_IDX_QTRIM_B 8'h3b
`define DQDT_IDX_DC0     8'h3c
`define DQDT_IDX_DC3     8'h3f
`define DQDT_IDX_CTRL    8'h40
`define DQDT_IDX_STAT    8'h41
// Fields and reset values
`define DQDT_BYP_BIT     6
`define DQDT_CFG_RST     8'h40
`define DQDT_CTRL_RST    8'h00
// Rate limits in quarter MSPS
`define DQDT_R153        12'h267
`define DQDT_R307        12'h4ce
`define DQDT_R500        12'h7d0
`define DQDT_R615        12'h99c
// Arithmetic constants
`define DQDT_ROOT_HALF   18'sh05a82
`define DQDT_TRIM_K      12'sh3e9
`define DQDT_FIR_SHIFT   8
`endif

// File: design/dqdt_pkg.sv
// Types of the quadrature trim datapath.
// Assumes nothing beyond the defines header.
package dqdt_pkg;
  typedef enum logic [2:0] {
    DQDT_NONE   = 3'b000,
    DQDT_HALF   = 3'b001,
    DQDT_QUART  = 3'b010,
    DQDT_THREEQ = 3'b011,
    DQDT_EIGHTH = 3'b100
  } dqdt_mix_e;
  typedef struct packed {
    logic        valid;
    logic [15:0] i;
    logic [15:0] q;
  } dqdt_sample_s;
endpackage

// File: design/dqdt_top.sv
// Quadrature mixing, phase trim, offset and inverse sinc datapath.
// Assumes samples from logic on mclk_i and an APB master on mclk_i.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "dqdt_defines.svh"
module dqdt_top
  import dqdt_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  // APB slave
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [11:0]  paddr_i,
  input  wire logic [31:0]  pwdata_i,
  input  wire logic [3:0]   pstrb_i,
  output logic      [31:0]  prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  // Sample stream
  input  wire dqdt_sample_s samp_i,
  output dqdt_sample_s      samp_o
);

////////////////////////////////////////////////////////////////////////
  function automatic logic reg_hit(input logic [7:0] x);
    reg_hit = (x == `DQDT_IDX_CFG) ||
              ((x >= `DQDT_IDX_ITRIM_A) && (x <= `DQDT_IDX_STAT));
  endfunction

  function automatic logic [15:0] sat16(input logic signed [17:0] x);
    if (x > 18'sh07fff) begin
      sat16 = 16'h7fff;
    end else if (x < -18'sh08000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = x[15:0];
    end
  endfunction

  function automatic logic signed [17:0] rmul(input logic signed [17:0] x);
    logic signed [35:0] p;
    p = x * `DQDT_ROOT_HALF;
    rmul = p[32:15];
  endfunction

  function automatic logic [11:0] max_rate(input logic word, input logic [2:0] hb);
    if (hb == 3'b111) begin
      max_rate = `DQDT_R153;
    end else if (!word) begin
      max_rate = `DQDT_R307;
    end else if (hb == 3'b000 || hb == 3'b010) begin
      max_rate = `DQDT_R615;
    end else if (hb == 3'b001) begin
      max_rate = `DQDT_R500;
    end else begin
      max_rate = `DQDT_R307;
    end
  endfunction

  function automatic logic signed [9:0] coef(input int k);
    case (k)
      0, 8:    coef = 10'sd1;
      1, 7:    coef = -10'sd3;
      2, 6:    coef = 10'sd8;
      3, 5:    coef = -10'sd30;
      default: coef = 10'sd225;
    endcase
  endfunction

////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]  cfg_q;
  logic [7:0]  ita_q;
  logic [1:0]  itb_q;
  logic [7:0]  qta_q;
  logic [1:0]  qtb_q;
  logic [7:0]  dc_q [4];
  logic [7:0]  ctrl_q;
  logic [11:0] rate_q;
  logic        sat_q;
  logic [7:0]  idx;
  logic        wr_en;
  logic [31:0] rd_d;

  assign idx   = paddr_i[9:2];
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
                 && (paddr_i[11:10] == 2'b00) && reg_hit(idx);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cfg_q  <= `DQDT_CFG_RST;
      ita_q  <= 8'h00;
      itb_q  <= 2'h0;
      qta_q  <= 8'h00;
      qtb_q  <= 2'h0;
      ctrl_q <= `DQDT_CTRL_RST;
      for (int k = 0; k < 4; k++) begin
        dc_q[k] <= 8'h00;
      end
    end else if (wr_en) begin
      if (idx == `DQDT_IDX_CFG) begin
        cfg_q <= pwdata_i[7:0];
      end else if (idx == `DQDT_IDX_ITRIM_A) begin
        ita_q <= pwdata_i[7:0];
      end else if (idx == `DQDT_IDX_ITRIM_B) begin
        itb_q <= pwdata_i[1:0];
      end else if (idx == `DQDT_IDX_QTRIM_A) begin
        qta_q <= pwdata_i[7:0];
      end else if (idx == `DQDT_IDX_QTRIM_B) begin
        qtb_q <= pwdata_i[1:0];
      end else if (idx >= `DQDT_IDX_DC0 && idx <= `DQDT_IDX_DC3) begin
        dc_q[idx[1:0]] <= pwdata_i[7:0];
      end else if (idx == `DQDT_IDX_CTRL) begin
        ctrl_q <= pwdata_i[7:0];
      end
    end
  end

  // Max input rate for bus width and stage mix
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rate_q <= `DQDT_R307;
    end else begin
      rate_q <= max_rate(ctrl_q[3], ctrl_q[6:4]);
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (idx == `DQDT_IDX_CFG) begin
      rd_d[7:0] = cfg_q;
    end else if (idx == `DQDT_IDX_ITRIM_A) begin
      rd_d[7:0] = ita_q;
    end else if (idx == `DQDT_IDX_ITRIM_B) begin
      rd_d[1:0] = itb_q;
    end else if (idx == `DQDT_IDX_QTRIM_A) begin
      rd_d[7:0] = qta_q;
    end else if (idx == `DQDT_IDX_QTRIM_B) begin
      rd_d[1:0] = qtb_q;
    end else if (idx >= `DQDT_IDX_DC0 && idx <= `DQDT_IDX_DC3) begin
      rd_d[7:0] = dc_q[idx[1:0]];
    end else if (idx == `DQDT_IDX_CTRL) begin
      rd_d[7:0] = ctrl_q;
    end else if (idx == `DQDT_IDX_STAT) begin
      rd_d[12:0] = {sat_q, rate_q};
    end
  end

  // Zero wait state answer, ready in the access cycle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i &&
                   ((paddr_i[11:10] != 2'b00) || !reg_hit(idx));
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= rd_d;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // Coarse mixing stage
  logic               [2:0]  ph_q;
  logic signed        [17:0] si, sq, mi, mq;
  logic               [15:0] mix_i_q, mix_q_q;
  logic                      mix_v_q;
  dqdt_mix_e                 mode;

  assign mode = dqdt_mix_e'(ctrl_q[2:0]);
  assign si   = 18'(signed'(samp_i.i));
  assign sq   = 18'(signed'(samp_i.q));

  always_comb begin
    mi = si;
    mq = sq;
    case (mode)
      DQDT_HALF: begin
        if (ph_q[0]) begin
          mi = -si;
          mq = -sq;
        end
      end
      DQDT_QUART: begin
        case (ph_q[1:0])
          2'd1:    begin mi = sq;  mq = -si; end
          2'd2:    begin mi = -si; mq = -sq; end
          2'd3:    begin mi = -sq; mq = si;  end
          default: begin mi = si;  mq = sq;  end
        endcase
      end
      DQDT_THREEQ: begin
        case (ph_q[1:0])
          2'd1:    begin mi = -sq; mq = si;  end
          2'd2:    begin mi = -si; mq = -sq; end
          2'd3:    begin mi = sq;  mq = -si; end
          default: begin mi = si;  mq = sq;  end
        endcase
      end
      DQDT_EIGHTH: begin
        case (ph_q)
          3'd1:    begin mi = rmul(si + sq);  mq = rmul(sq - si);  end
          3'd2:    begin mi = sq;             mq = -si;            end
          3'd3:    begin mi = rmul(sq - si);  mq = -rmul(sq + si); end
          3'd4:    begin mi = -si;            mq = -sq;            end
          3'd5:    begin mi = -rmul(si + sq); mq = rmul(si - sq);  end
          3'd6:    begin mi = -sq;            mq = si;             end
          3'd7:    begin mi = rmul(si - sq);  mq = rmul(sq + si);  end
          default: begin mi = si;             mq = sq;             end
        endcase
      end
      default: begin
        mi = si;
        mq = sq;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ph_q    <= 3'd0;
      mix_v_q <= 1'b0;
      mix_i_q <= 16'h0000;
      mix_q_q <= 16'h0000;
    end else begin
      mix_v_q <= samp_i.valid;
      if (samp_i.valid) begin
        ph_q    <= ph_q + 3'd1;
        mix_i_q <= sat16(mi);
        mix_q_q <= sat16(mq);
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // Phase trim stage, small angle rotation
  logic signed [9:0]  itrim, qtrim;
  logic signed [37:0] pi_prod, pq_prod;
  logic signed [17:0] ti, tq;
  logic        [15:0] ph_i_q, ph_q_q;
  logic               ph_v_q;

  assign itrim   = signed'({itb_q, ita_q});
  assign qtrim   = signed'({qtb_q, qta_q});
  assign pi_prod = itrim * signed'(mix_q_q) * `DQDT_TRIM_K;
  assign pq_prod = qtrim * signed'(mix_i_q) * `DQDT_TRIM_K;
  assign ti      = 18'(signed'(mix_i_q)) - 18'(pi_prod >>> 24);
  assign tq      = 18'(signed'(mix_q_q)) - 18'(pq_prod >>> 24);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ph_v_q <= 1'b0;
      ph_i_q <= 16'h0000;
      ph_q_q <= 16'h0000;
    end else begin
      ph_v_q <= mix_v_q;
      if (mix_v_q) begin
        ph_i_q <= sat16(ti);
        ph_q_q <= sat16(tq);
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // Offset stage
  logic signed [17:0] oi, oq;
  logic        [15:0] off_i_q, off_q_q;
  logic               off_v_q;

  assign oi = 18'(signed'(ph_i_q)) + 18'(signed'({dc_q[1], dc_q[0]}));
  assign oq = 18'(signed'(ph_q_q)) + 18'(signed'({dc_q[3], dc_q[2]}));

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      off_v_q <= 1'b0;
      off_i_q <= 16'h0000;
      off_q_q <= 16'h0000;
      sat_q   <= 1'b0;
    end else begin
      off_v_q <= ph_v_q;
      if (ph_v_q) begin
        off_i_q <= sat16(oi);
        off_q_q <= sat16(oq);
        sat_q   <= (sat16(oi) != oi[15:0]) || (sat16(oq) != oq[15:0]);
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  // Inverse sinc stage
  logic        [15:0] tap_q [2][8];
  logic        [15:0] cur   [2];
  logic signed [29:0] acc   [2];
  logic        [15:0] fir   [2];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
        for (int k = 0; k < 8; k++) begin
          tap_q[c][k] <= 16'h0000;
        end
      end else if (off_v_q) begin
        tap_q[c][0] <= cur[c];
        for (int k = 1; k < 8; k++) begin
          tap_q[c][k] <= tap_q[c][k-1];
        end
      end
    end

    // Newest sample is tap zero, older ones come from the delay line
    always_comb begin
      cur[c] = (c == 0) ? off_i_q : off_q_q;
      acc[c] = signed'(cur[c]) * coef(0);
      for (int k = 1; k < 9; k++) begin
        acc[c] = acc[c] + signed'(tap_q[c][k-1]) * coef(k);
      end
      fir[c] = sat16(acc[c][17+`DQDT_FIR_SHIFT:`DQDT_FIR_SHIFT]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      samp_o <= '0;
    end else begin
      samp_o.valid <= off_v_q;
      if (off_v_q) begin
        if (cfg_q[`DQDT_BYP_BIT]) begin
          samp_o.i <= off_i_q;
          samp_o.q <= off_q_q;
        end else begin
          samp_o.i <= fir[0];
          samp_o.q <= fir[1];
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_in;
    samp_i.valid;
  endsequence
  sequence s_out;
    ##4 samp_o.valid;
  endsequence

  AST_BYP_RESET: assert property ($rose(reset_n_i) |-> cfg_q[`DQDT_BYP_BIT])
    else $error("inverse sinc not bypassed after reset");
  AST_LATENCY: assert property (s_in |-> s_out)
    else $error("sample did not reach output in four cycles");
  AST_HALF_MIX: assert property (samp_i.valid && mode == DQDT_HALF && ph_q[0]
    |=> mix_i_q == sat16(-$past(si)))
    else $error("half rate mix sign wrong");
  AST_QUART_MIX: assert property (samp_i.valid && mode == DQDT_QUART && ph_q == 3'd1
    |=> mix_i_q == $past(samp_i.q))
    else $error("quarter rate mix wrong");
  AST_PHASE_STEP: assert property (samp_i.valid |=> ph_q == $past(ph_q) + 3'd1)
    else $error("mix phase did not advance");
  AST_TRIM_ZERO: assert property (mix_v_q && itrim == 10'sd0
    |=> ph_i_q == $past(mix_i_q))
    else $error("zero trim altered I");
  AST_DC_ZERO: assert property (ph_v_q && dc_q[0] == 8'h00 && dc_q[1] == 8'h00
    |=> off_i_q == $past(ph_i_q))
    else $error("zero offset altered I");
  AST_SAT: assert property (ph_v_q && oi > 18'sh07fff |=> off_i_q == 16'h7fff)
    else $error("offset sum wrapped");
  AST_BYP_PATH: assert property (off_v_q && cfg_q[`DQDT_BYP_BIT]
    |=> samp_o.i == $past(off_i_q))
    else $error("bypass path wrong");
  AST_RATE: assert property (ctrl_q[6:4] == 3'b111 ##1 ctrl_q[6:4] == 3'b111
    |-> rate_q == `DQDT_R153)
    else $error("rate limit wrong");
  AST_UNMAPPED: assert property (psel_i && !penable_i
    && ((paddr_i[11:10] != 2'b00) || !reg_hit(idx))
    |=> pslverr_o && pready_o)
    else $error("unmapped access not flagged");
endmodule
